// *** hdl/scss_top.sv ***
// System clock source selector: registers, source sampling and glitch-free switch.
// Assumes clock sources arrive as pins unrelated to clk_sys, and a register
// master that issues one-cycle strobes on clk_sys.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "scss_consts.svh"
module scss_top
	import scss_pkg::*;
(
	// Clock and reset
	input  wire logic                     clk_sys,
	input  wire logic                     nrst,
	// Register port
	input  wire logic [`SCSS_ADDR_W-1:0]  addr,
	input  wire logic [`SCSS_DATA_W-1:0]  wr_data,
	input  wire logic                     wr_stb,
	input  wire logic                     rd_stb,
	output var  logic [`SCSS_DATA_W-1:0]  rd_data_q,
	// Clock source pins
	input  wire logic                     crystal_input,
	input  wire logic                     internal_clock,
	input  wire logic                     direct_clock_input,
	input  wire logic                     wakeup_clock,
	// Generated system clock and status
	output var  logic                     sys_clk_q,
	output var  logic                     switch_busy_q
);
	logic        rst_meta_q;
	logic        rst_n;
	logic [3:0]  pin_meta_q;
	logic [3:0]  pin_q;
	logic [3:0]  pin_prev_q;
	logic [3:0]  pin_rise;

	logic [1:0]  clock_source_select_q;
	logic        vco_bypass_q;
	logic        osc_source_sel_q;
	logic [3:0]  pll_input_divider_field_q;
	logic [7:0]  pll_feedback_factor_field_q;
	logic [9:0]  output_prescaler_field_q;
	logic [6:0]  pll_output_divider_field_q;

	scss_mode_e  want_mode;
	scss_mode_e  act_mode_q;
	scss_state_e state_q;
	logic        osc_lvl;
	logic        osc_rise;
	logic        presc_lvl;
	logic        pll_lvl;
	logic        pll_en;
	logic        lvl_act;
	logic        lvl_want;
	logic        switch_go;
	logic [15:0] rd_val;

	// Pin order inside the sampled vector.
	localparam int PIN_XTAL = 0;
	localparam int PIN_INT  = 1;
	localparam int PIN_DIR  = 2;
	localparam int PIN_WU   = 3;

	function automatic scss_mode_e decode_mode(input logic [1:0] sel, input logic bypass);
		if (sel == `SCSS_SEL_DIRECT)
			return mode_direct;
		else if (sel == `SCSS_SEL_DIVIDED)
			return bypass ? mode_presc : mode_pll;
		else
			return mode_wakeup;
	endfunction

	function automatic logic mode_level(input scss_mode_e m, input logic wu,
		input logic dir, input logic presc, input logic pll);
		case (m)
			mode_direct: return dir;
			mode_presc:  return presc;
			mode_pll:    return pll;
			default:     return wu;
		endcase
	endfunction

	// Reset release synchroniser.
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// Every source clock is foreign to clk_sys and is sampled twice first.
	// The generated clock thus carries up to one clk_sys period of jitter.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_meta_q <= 4'h0;
			pin_q      <= 4'h0;
			pin_prev_q <= 4'h0;
		end
		else
		begin
			pin_meta_q <= {wakeup_clock, direct_clock_input, internal_clock, crystal_input};
			pin_q      <= pin_meta_q;
			pin_prev_q <= pin_q;
		end
	end

	always_comb
	begin
		pin_rise = pin_q & ~pin_prev_q;
		osc_lvl  = osc_source_sel_q ? pin_q[PIN_XTAL] : pin_q[PIN_INT];
		osc_rise = osc_source_sel_q ? pin_rise[PIN_XTAL] : pin_rise[PIN_INT];
		want_mode = decode_mode(clock_source_select_q, vco_bypass_q);
		pll_en    = (want_mode == mode_pll) || (act_mode_q == mode_pll);
	end

	// Register writes.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			clock_source_select_q <= `SCSS_SEL_RST;
		else if (wr_stb && addr == `SCSS_ADDR_SYSCFG0)
			clock_source_select_q <= wr_data[`SCSS_SEL_MSB:`SCSS_SEL_LSB];
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			vco_bypass_q                <= `SCSS_BYPASS_RST;
			osc_source_sel_q            <= `SCSS_OSCSRC_RST;
			pll_input_divider_field_q   <= `SCSS_PLL_INPUT_DIVIDER_FIELD_RST;
			pll_feedback_factor_field_q <= `SCSS_PLL_FEEDBACK_FACTOR_FIELD_RST;
		end
		else if (wr_stb && addr == `SCSS_ADDR_PLLCFG0)
		begin
			vco_bypass_q                <= wr_data[`SCSS_BYPASS_BIT];
			osc_source_sel_q            <= wr_data[`SCSS_OSCSRC_BIT];
			pll_input_divider_field_q   <= wr_data[`SCSS_PLL_INPUT_DIVIDER_FIELD_MSB:`SCSS_PLL_INPUT_DIVIDER_FIELD_LSB];
			pll_feedback_factor_field_q <= wr_data[`SCSS_PLL_FEEDBACK_FACTOR_FIELD_MSB:`SCSS_PLL_FEEDBACK_FACTOR_FIELD_LSB];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			output_prescaler_field_q <= `SCSS_K1_RST;
		else if (wr_stb && addr == `SCSS_ADDR_PRESCFG)
			output_prescaler_field_q <= wr_data[`SCSS_K1_MSB:`SCSS_K1_LSB];
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			pll_output_divider_field_q <= `SCSS_K2_RST;
		else if (wr_stb && addr == `SCSS_ADDR_PLLCFG1)
			pll_output_divider_field_q <= wr_data[`SCSS_K2_MSB:`SCSS_K2_LSB];
	end

	// Register reads; data stand only in the cycle after the strobe.
	always_comb
	begin
		rd_val = 16'h0000;
		if (addr == `SCSS_ADDR_SYSCFG0)
			rd_val[`SCSS_SEL_MSB:`SCSS_SEL_LSB] = clock_source_select_q;
		else if (addr == `SCSS_ADDR_PLLCFG0)
		begin
			rd_val[`SCSS_BYPASS_BIT] = vco_bypass_q;
			rd_val[`SCSS_OSCSRC_BIT] = osc_source_sel_q;
			rd_val[`SCSS_PLL_INPUT_DIVIDER_FIELD_MSB:`SCSS_PLL_INPUT_DIVIDER_FIELD_LSB] = pll_input_divider_field_q;
			rd_val[`SCSS_PLL_FEEDBACK_FACTOR_FIELD_MSB:`SCSS_PLL_FEEDBACK_FACTOR_FIELD_LSB] = pll_feedback_factor_field_q;
		end
		else if (addr == `SCSS_ADDR_PRESCFG)
			rd_val[`SCSS_K1_MSB:`SCSS_K1_LSB] = output_prescaler_field_q;
		else if (addr == `SCSS_ADDR_PLLCFG1)
			rd_val[`SCSS_K2_MSB:`SCSS_K2_LSB] = pll_output_divider_field_q;
		else if (addr == `SCSS_ADDR_STATUS)
			rd_val[4:0] = {sys_clk_q, switch_busy_q, state_q == st_park, act_mode_q};
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			rd_data_q <= 16'h0000;
		else
			rd_data_q <= rd_stb ? rd_val : 16'h0000;
	end

	scss_prescaler u_presc
	(
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.src_lvl  (osc_lvl),
		.src_rise (osc_rise),
		.k1_field (output_prescaler_field_q),
		.div_q    (presc_lvl)
	);

	scss_pll u_pll
	(
		.clk_sys  (clk_sys),
		.rst_n    (rst_n),
		.enable   (pll_en),
		.ref_rise (osc_rise),
		.pll_input_divider_field     (pll_input_divider_field_q),
		.pll_feedback_factor_field     (pll_feedback_factor_field_q),
		.pll_output_divider_field    (pll_output_divider_field_q),
		.pll_q    (pll_lvl)
	);

	always_comb
	begin
		lvl_act  = mode_level(act_mode_q, pin_q[PIN_WU], pin_q[PIN_DIR], presc_lvl, pll_lvl);
		lvl_want = mode_level(want_mode, pin_q[PIN_WU], pin_q[PIN_DIR], presc_lvl, pll_lvl);
		// Leave the old source only while it and the output are both low.
		switch_go = (state_q == st_run) && (want_mode != act_mode_q)
			&& !sys_clk_q && !lvl_act;
	end

	// The parked output joins the new source only at one of its low phases,
	// so a high phase is never cut short; a low phase may stretch instead.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q    <= st_run;
			act_mode_q <= mode_wakeup;
		end
		else
		begin
			case (state_q)
				st_run:
					if (switch_go)
						state_q <= st_park;
				st_park:
					if (!lvl_want)
					begin
						act_mode_q <= want_mode;
						state_q    <= st_run;
					end
				default:
					state_q <= st_run;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			sys_clk_q <= 1'b0;
		else if (state_q == st_run && !switch_go)
			sys_clk_q <= lvl_act;
		else
			sys_clk_q <= 1'b0;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			switch_busy_q <= 1'b0;
		else
			switch_busy_q <= (want_mode != act_mode_q) || (state_q == st_park);
	end
endmodule // scss_top
`default_nettype wire

// *** hdl/scss_consts.svh ***
// Register offsets, field positions and reset values of the system clock selector.
// Assumes a 16-bit register port with one register per address.
// Functional notes
// - Selector 11 passes the direct clock input through.
// - Selector 10 with bypass divides the oscillator.
// - Prescaler divides by field value plus one.
// - Prescaler source is crystal or internal clock.
// - Factor one passes source clock unchanged.
// - Factors up to 1024 give lowest frequency.
// - Selector 10 without bypass runs the PLL.
// - PLL factor is feedback over input times output.
// - Selector 00 runs from the wakeup clock.
`ifndef SCSS_CONSTS_SVH
`define SCSS_CONSTS_SVH

`define SCSS_ADDR_W          4
`define SCSS_DATA_W          16
`define SCSS_ADDR_SYSCFG0    4'h0
`define SCSS_ADDR_PLLCFG0    4'h1
`define SCSS_ADDR_PRESCFG    4'h2
`define SCSS_ADDR_PLLCFG1    4'h3
`define SCSS_ADDR_STATUS     4'h4

`define SCSS_SEL_MSB         1
`define SCSS_SEL_LSB         0
`define SCSS_BYPASS_BIT      0
`define SCSS_OSCSRC_BIT      1
`define SCSS_PLL_INPUT_DIVIDER_FIELD_MSB        7
`define SCSS_PLL_INPUT_DIVIDER_FIELD_LSB        4
`define SCSS_PLL_FEEDBACK_FACTOR_FIELD_MSB        15
`define SCSS_PLL_FEEDBACK_FACTOR_FIELD_LSB        8
`define SCSS_K1_MSB          9
`define SCSS_K1_LSB          0
`define SCSS_K2_MSB          6
`define SCSS_K2_LSB          0

`define SCSS_SEL_RST         2'h0
`define SCSS_BYPASS_RST      1'b1
`define SCSS_OSCSRC_RST      1'b0
`define SCSS_PLL_INPUT_DIVIDER_FIELD_RST        4'h0
`define SCSS_PLL_FEEDBACK_FACTOR_FIELD_RST        8'h00
`define SCSS_K1_RST          10'h000
`define SCSS_K2_RST          7'h00

`define SCSS_SEL_DIRECT      2'h3
`define SCSS_SEL_DIVIDED     2'h2
`define SCSS_PER_W           16

`endif

// *** hdl/scss_pkg.sv ***
// Types and shared arithmetic of the system clock selector.
// Assumes nothing of its surroundings.
package scss_pkg;

	typedef enum logic [1:0] {
		mode_wakeup,
		mode_pll,
		mode_presc,
		mode_direct
	} scss_mode_e;

	typedef enum logic [0:0] {
		st_run,
		st_park
	} scss_state_e;

	// A divider field holds the factor minus one.
	function automatic logic [10:0] scss_plus_one(input logic [9:0] field);
		return {1'b0, field} + 11'h001;
	endfunction

endpackage

// *** hdl/scss_prescaler.sv ***
// Output prescaler that divides a sampled source clock by a programmable factor.
// Assumes src_lvl and src_rise come from synchronised flops on clk_sys.
`timescale 1ns/1ns
`default_nettype none
module scss_prescaler
	import scss_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// Source clock, sampled
	input  wire logic       src_lvl,
	input  wire logic       src_rise,
	// Divider field
	input  wire logic [9:0] k1_field,
	// Divided clock level
	output var  logic       div_q
);
	logic [10:0] k_cur_q;
	logic [10:0] k_eff;
	logic [9:0]  cnt_q;
	logic [9:0]  cnt_d;
	logic        wrap;
	logic        div_d;

	always_comb
	begin
		// A new factor is taken only at a period boundary.
		wrap  = src_rise && ({1'b0, cnt_q} >= (k_cur_q - 11'h001));
		k_eff = wrap ? scss_plus_one(k1_field) : k_cur_q;
		if (wrap)
			cnt_d = 10'h000;
		else if (src_rise)
			cnt_d = cnt_q + 10'h001;
		else
			cnt_d = cnt_q;
		if (k_eff == 11'h001)
			div_d = src_lvl;
		else if (src_rise)
			div_d = ({1'b0, cnt_d} < ((k_eff + 11'h001) >> 1));
		else
			div_d = div_q;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			k_cur_q <= 11'h001;
		else if (wrap)
			k_cur_q <= k_eff;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			cnt_q <= 10'h000;
		else
			cnt_q <= cnt_d;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			div_q <= 1'b0;
		else
			div_q <= div_d;
	end
endmodule // scss_prescaler
`default_nettype wire

// *** hdl/scss_pll.sv ***
// Digital frequency synthesiser standing in for the PLL.
// Assumes ref_rise is a one-cycle pulse per reference period, on clk_sys.
`timescale 1ns/1ns
`default_nettype none
`include "scss_consts.svh"
module scss_pll
	import scss_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// Control
	input  wire logic       enable,
	input  wire logic       ref_rise,
	input  wire logic [3:0] pll_input_divider_field,
	input  wire logic [7:0] pll_feedback_factor_field,
	input  wire logic [6:0] pll_output_divider_field,
	// Synthesised clock level
	output var  logic       pll_q
);
	localparam int PW = `SCSS_PER_W;

	logic [PW-1:0] cnt_q;
	logic [PW-1:0] per_q;
	logic          valid_q;
	logic [31:0]   acc_q;
	logic [31:0]   thr;
	logic [31:0]   sum;
	logic [31:0]   inc;

	// The output toggles 2*N times per P*K2 reference periods, so its rate
	// is the reference rate times N/(P*K2); it cannot exceed half of clk_sys.
	always_comb
	begin
		thr = 32'(per_q) * 32'(scss_plus_one({6'h00, pll_input_divider_field}))
			* 32'(scss_plus_one({3'h0, pll_output_divider_field}));
		inc = 32'(scss_plus_one({2'h0, pll_feedback_factor_field})) << 1;
		sum = acc_q + inc;
	end

	// The period estimate only moves at reference edges, so the frequency changes in steps.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q   <= '0;
			per_q   <= '0;
			valid_q <= 1'b0;
		end
		else if (!enable)
		begin
			cnt_q   <= '0;
			valid_q <= 1'b0;
		end
		else if (ref_rise)
		begin
			cnt_q   <= PW'(1);
			per_q   <= (cnt_q == '0) ? PW'(1) : cnt_q;
			valid_q <= valid_q || (cnt_q != '0);
		end
		else if (cnt_q != '1)
			cnt_q <= cnt_q + PW'(1);
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc_q <= '0;
			pll_q <= 1'b0;
		end
		else if (!enable || !valid_q)
		begin
			acc_q <= '0;
			pll_q <= 1'b0;
		end
		else if (sum >= thr)
		begin
			acc_q <= (sum - thr < thr) ? sum - thr : 32'h0000_0000;
			pll_q <= !pll_q;
		end
		else
			acc_q <= sum;
	end
endmodule // scss_pll
`default_nettype wire

// *** tb/scss_top_sva.sv ***
// Checker for the system clock selector, bound to the top module's ports.
// Assumes the bench keeps every source no faster than a sixth of clk_sys.
`timescale 1ns/1ns
`default_nettype none
`include "scss_consts.svh"
module scss_top_sva
(
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       nrst,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [15:0] wr_data,
	input wire logic       wr_stb,
	input wire logic       rd_stb,
	input wire logic [15:0] rd_data_q,
	// Sources and outputs
	input wire logic       crystal_input,
	input wire logic       internal_clock,
	input wire logic       direct_clock_input,
	input wire logic       wakeup_clock,
	input wire logic       sys_clk_q,
	input wire logic       switch_busy_q
);
	logic [1:0] sel_q;
	logic       byp_q;
	logic       osc_q;
	logic [9:0] k1_q;
	logic [7:0] quiet_q;
	logic       settled;
	logic       pll_m;
	logic       osc_src;

	function automatic logic [1:0] md(input logic [1:0] s, input logic b);
		return (s == 2'h3) ? 2'h3 : (s == 2'h2) ? (b ? 2'h2 : 2'h1) : 2'h0;
	endfunction

	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
		begin
			sel_q <= 2'h0;
			byp_q <= 1'b1;
			osc_q <= 1'b0;
			k1_q  <= 10'h000;
		end
		else if (wr_stb && addr == 4'h0)
			sel_q <= wr_data[1:0];
		else if (wr_stb && addr == 4'h1)
			{osc_q, byp_q} <= wr_data[1:0];
		else if (wr_stb && addr == 4'h2)
			k1_q <= wr_data[9:0];

	// Source fields may retime a switch, so only long quiet stretches are compared.
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
			quiet_q <= 8'h00;
		else if (switch_busy_q || (wr_stb && addr < 4'h4))
			quiet_q <= 8'h00;
		else if (quiet_q != 8'hff)
			quiet_q <= quiet_q + 8'h01;

	assign settled = quiet_q > 8'hc8;
	assign pll_m   = sel_q == 2'h2 && !byp_q;
	assign osc_src = osc_q ? crystal_input : internal_clock;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	property p_rd_idle; !rd_stb |=> rd_data_q == 16'h0000; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
	property p_rd_unmapped; rd_stb && addr > 4'h4 |=> rd_data_q == 16'h0000; endproperty
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
	property p_rd_presc; rd_stb && addr == 4'h2 |=> rd_data_q == {6'h00, $past(k1_q)}; endproperty
	a_rd_presc: assert property (p_rd_presc) else $error("divider field read wrong");
	property p_status;
		rd_stb && addr == 4'h4 |=> rd_data_q[4:3] == $past({sys_clk_q, switch_busy_q});
	endproperty
	a_status: assert property (p_status) else $error("status bits wrong");
	property p_direct; settled && sel_q == 2'h3 |-> sys_clk_q == $past(direct_clock_input, 3);
	endproperty
	a_direct: assert property (p_direct) else $error("direct clock not followed");
	property p_wake; settled && sel_q < 2'h2 |-> sys_clk_q == $past(wakeup_clock, 3); endproperty
	a_wake: assert property (p_wake) else $error("wakeup clock not followed");
	property p_pass;
		settled && sel_q == 2'h2 && byp_q && k1_q == 10'h000 |-> sys_clk_q == $past(osc_src, 4);
	endproperty
	a_pass: assert property (p_pass) else $error("factor one not passed");
	property p_busy;
		wr_stb && addr == 4'h0 && !switch_busy_q && md(wr_data[1:0], byp_q) != md(sel_q, byp_q)
			|-> ##[1:2] switch_busy_q;
	endproperty
	a_busy: assert property (p_busy) else $error("mode change without busy");
	property p_hi; $rose(sys_clk_q) && !pll_m |=> sys_clk_q [*2]; endproperty
	a_hi: assert property (p_hi) else $error("short high phase");
	property p_lo; $fell(sys_clk_q) && !pll_m |=> !sys_clk_q [*2]; endproperty
	a_lo: assert property (p_lo) else $error("short low phase");
	// The output follows the new source from the cycle after the handover,
	// so the parked low level is looked for in the two cycles before busy drops.
	property p_handover;
		$fell(switch_busy_q) |-> !$past(sys_clk_q) && !$past(sys_clk_q, 2);
	endproperty
	a_handover: assert property (p_handover) else $error("handover while high");

	c_direct: cover property (settled && sel_q == 2'h3);
	c_busy: cover property ($rose(switch_busy_q));
	c_unmapped: cover property (rd_stb && addr > 4'h4);
endmodule // scss_top_sva
`default_nettype wire

// *** tb/tb_scss_top.sv ***
// Self-checking bench for the system clock selector: registers, modes and periods.
// Assumes the design and the checker file are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module tb_scss_top;
	logic clk_sys = 1'b0, nrst = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wr_data = 16'h0000, rd_data_q, r, d;
	logic [3:0] src = 4'h0;
	int src_cnt [4] = '{0, 0, 0, 0};
	int src_half [4] = '{5, 7, 6, 20};
	logic sys_clk_q, switch_busy_q;
	logic [15:0] msk [5] = '{16'h0003, 16'hfff3, 16'h03ff, 16'h007f, 16'h0003};
	logic [15:0] rv [5] = '{16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000};
	integer seed = 80757;
	int num_errors = 0, n_checks = 0, n, a, t;
	int ks [4] = '{1, 2, 0, 1023};

	always #4 clk_sys = ~clk_sys;

	// Sources toggle after whole numbers of clk_sys cycles, so every period is exact.
	// Order: crystal, internal, direct, wakeup.
	always @(posedge clk_sys)
	begin
		for (int k = 0; k < 4; k++)
		begin
			if (src_cnt[k] == src_half[k] - 1)
			begin
				src_cnt[k] <= 0;
				src[k]     <= ~src[k];
			end
			else
				src_cnt[k] <= src_cnt[k] + 1;
		end
	end

	scss_top uut (.clk_sys(clk_sys), .nrst(nrst), .addr(addr), .wr_data(wr_data),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data_q(rd_data_q),
		.crystal_input(src[0]), .internal_clock(src[1]),
		.direct_clock_input(src[2]), .wakeup_clock(src[3]),
		.sys_clk_q(sys_clk_q), .switch_busy_q(switch_busy_q));

	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		n_checks++;
		if (s !== e)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic wr(input int ad, input logic [15:0] dt);
		@(posedge clk_sys);
		addr <= 4'(ad);
		wr_data <= dt;
		wr_stb <= 1'b1;
		@(posedge clk_sys);
		wr_stb <= 1'b0;
	endtask

	task automatic rd(input int ad, output logic [15:0] dt);
		@(posedge clk_sys);
		addr <= 4'(ad);
		rd_stb <= 1'b1;
		@(posedge clk_sys);
		rd_stb <= 1'b0;
		@(negedge clk_sys);
		dt = rd_data_q;
	endtask

	// Counts cycles until the chosen output reaches a level; a hang ends the run.
	task automatic wl(input bit b, input logic v, inout int c);
		int i;
		for (i = 0; i < 30000 && ((b ? switch_busy_q : sys_clk_q) !== v); i++)
		begin
			@(negedge clk_sys);
			c++;
		end
		if (i == 30000)
		begin
			num_errors++;
			end_of_test();
		end
	endtask

	// The first period after a change is skipped, as a new factor waits for a boundary.
	task automatic per(output int p);
		int u;
		u = 0;
		wl(0, 0, u);
		wl(0, 1, u);
		wl(0, 0, u);
		wl(0, 1, u);
		p = 0;
		wl(0, 0, p);
		wl(0, 1, p);
	endtask

	task automatic sw(input int ad, input logic [15:0] dt, input logic [15:0] m);
		wr(ad, dt);
		repeat (4) @(posedge clk_sys);
		wl(1, 0, t);
		rd(4, r);
		chk("mode", r & 16'h0003, m);
	endtask

	initial
	begin
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		for (a = 0; a < 5; a++)
		begin
			rd(a, r);
			chk("reset", r & msk[a], rv[a]);
		end
		repeat (12)
		begin
			a = 1 + $unsigned($random(seed)) % 3;
			d = 16'($random(seed));
			wr(a, d);
			rd(a, r);
			chk("rdback", r, d & msk[a]);
		end
		repeat (6)
		begin
			a = 4 + $unsigned($random(seed)) % 12;
			wr(a, 16'($random(seed)));
			rd(a, r);
			chk("unmapped", r & ((a == 4) ? 16'hffe0 : 16'hffff), 16'h0000);
		end
		wr(1, 16'h0001);
		wr(2, 16'h0000);
		wr(3, 16'h0000);
		// A large factor written at random may still be pending in the prescaler;
		// let the slowest possible period run out before factor one is checked.
		repeat (14500) @(posedge clk_sys);
		per(n);
		chk("wake_per", 16'(n), 16'h0028);
		sw(0, 16'h0003, 16'h0003);
		per(n);
		chk("direct_per", 16'(n), 16'h000c);
		sw(0, 16'h0002, 16'h0002);
		per(n);
		chk("internal_per", 16'(n), 16'h000e);
		// The oscillator source is changed only while another mode drives the output.
		sw(0, 16'h0003, 16'h0003);
		wr(1, 16'h0003);
		sw(0, 16'h0002, 16'h0002);
		per(n);
		chk("crystal_per", 16'(n), 16'h000a);
		ks[2] = 3 + $unsigned($random(seed)) % 100;
		foreach (ks[i])
		begin
			wr(2, 16'(ks[i]));
			per(n);
			chk("presc_per", 16'(n), 16'((ks[i] + 1) * 10));
		end
		wr(3, 16'h0001);
		sw(1, 16'h0302, 16'h0001);
		per(n);
		chk("pll_per", 16'(n >= 4 && n <= 6), 16'h0001);
		end_of_test();
	end
endmodule // tb_scss_top

bind scss_top scss_top_sva u_sva (.clk_sys(clk_sys), .nrst(nrst), .addr(addr),
	.wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data_q(rd_data_q),
	.crystal_input(crystal_input), .internal_clock(internal_clock),
	.direct_clock_input(direct_clock_input), .wakeup_clock(wakeup_clock),
	.sys_clk_q(sys_clk_q), .switch_busy_q(switch_busy_q));
`default_nettype wire
